//--- core/lcu_pkg.sv
// Shared types and constants of the logic, compare and transfer datapath.
// Assumes a 100 MHz machine clock and 28-bit words with bit 27 as sign.
package lcu_pkg;
    localparam int WORD_W = 28;
    localparam int IDX_W  = 14;

    // Time before a zero-count scan or table compare gives up
    localparam int CLK_PERIOD_NS = 10;
    localparam int ZERO_STOP_NS  = 6000;
    localparam int ZERO_STOP_CYC = (ZERO_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [IDX_W-1:0]  STEP_ONE  = 14'h0001;
    localparam logic [IDX_W-1:0]  STEP_SKIP = 14'h0002;
    localparam logic [WORD_W-1:0] WORD_RST  = 28'h0000000;
    localparam logic [IDX_W-1:0]  IDX_RST   = 14'h0000;
    localparam logic [WORD_W-1:0] C_STEP    = 28'h0000001;

    typedef enum logic [4:0] {
        OP_IDX_DEC2, OP_IDX_DEC3, OP_AND, OP_AND_MEM, OP_OR, OP_OR_MEM, OP_XOR,
        OP_CMP_EQ, OP_CMP_NE, OP_CMP_GR, OP_CMP_LS,
        OP_SCAN_EQ, OP_SCAN_NE, OP_SCAN_GR, OP_SCAN_LS,
        OP_TCMP_EQ, OP_TCMP_NE,
        OP_COPY_C, OP_COPY_I1, OP_COPY_I2, OP_COPY_I3,
        OP_COPY_XH, OP_COPY_XC, OP_COPY_M, OP_COPY_Q
    } lcu_op_e;

    typedef enum logic [1:0] { CMP_EQ, CMP_NE, CMP_GR, CMP_LS } lcu_cmp_e;

    typedef enum logic [2:0] { PH_IDLE, PH_WRITE, PH_ZERO, PH_SCAN, PH_TREF, PH_TUNK } lcu_phase_e;

    typedef struct packed {
        logic [WORD_W-1:0] a;
        logic [WORD_W-1:0] b;
        logic [WORD_W-1:0] c;
        logic [IDX_W-1:0]  x;
        logic [IDX_W-1:0]  i1;
        logic [IDX_W-1:0]  i2;
        logic [IDX_W-1:0]  i3;
        logic [WORD_W-1:0] m;
        logic [WORD_W-1:0] q;
    } lcu_regs_s;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [IDX_W-1:0]  addr;
        logic [WORD_W-1:0] wdata;
    } lcu_mem_req_s;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] rdata;
    } lcu_mem_rsp_s;

    typedef struct packed {
        lcu_phase_e        phase;
        lcu_op_e           op;
        logic              masked;
        lcu_regs_s         regs;
        logic [IDX_W-1:0]  current_instruction_address;
        logic [IDX_W-1:0]  next_instruction_address;
        logic [IDX_W-1:0]  ptr;
        logic [IDX_W-1:0]  remain;
        logic [WORD_W-1:0] refWord;
        logic              done;
        lcu_mem_req_s      mem;
    } lcu_state_s;

    typedef struct packed {
        logic        running;
        logic [15:0] count;
    } lcu_timer_s;
endpackage

//--- core/lcu_compare.sv
// Algebraic word comparator with optional masking of both sides.
// Assumes two's complement words; purely combinational.
`timescale 1ns/10ps
module lcu_compare #(
    parameter int WIDTH = lcu_pkg::WORD_W
) (
    input  wire logic [WIDTH-1:0] left,
    input  wire logic [WIDTH-1:0] right,
    input  wire logic [WIDTH-1:0] mask,
    input  wire logic             masked,
    input  wire lcu_pkg::lcu_cmp_e kind,
    output logic                  hit
);
    logic [WIDTH-1:0] useMask;
    logic [WIDTH-1:0] l;
    logic [WIDTH-1:0] r;

    always_comb begin
        useMask = masked ? mask : '1;
        l       = left & useMask;
        r       = right & useMask;
        case (kind)
            lcu_pkg::CMP_EQ: hit = (l == r);
            lcu_pkg::CMP_NE: hit = (l != r);
            lcu_pkg::CMP_GR: hit = ($signed(l) > $signed(r));
            lcu_pkg::CMP_LS: hit = ($signed(l) < $signed(r));
            default:         hit = 1'b0;
        endcase
    end
endmodule

//--- core/lcu_timer.sv
// One-shot cycle timer; expired is high for the last counted cycle.
// Assumes load is a single-cycle pulse on the same clock.
`timescale 1ns/10ps
module lcu_timer #(
    parameter int CYCLES = lcu_pkg::ZERO_STOP_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic load,
    output logic      expired
);
    lcu_pkg::lcu_timer_s st;
    lcu_pkg::lcu_timer_s next_st;

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.running = 1'b1;
            next_st.count   = 16'(CYCLES - 1);
        end else if (st.running) begin
            if (st.count == 16'h0000) begin
                next_st.running = 1'b0;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.running && (st.count == 16'h0000);
endmodule

//--- core/lcu_core.sv
// Logic, compare and transfer datapath of the word machine.
// Assumes the sequencer gives opcode, operand and register snapshot with start,
// and a core memory that answers each held request with a one-cycle valid.
//
// Behaviour
// - Index decrement subtracts operand from index 2 or 3, modulo 2^14, no flags.
// - Masked index decrement ANDs operand with mask before subtracting.
// - AND of accumulator and operand; masked result then ANDed with mask.
// - AND-to-memory writes accumulator AND memory word to memory and C.
// - OR of accumulator and operand; masked result then ANDed with mask.
// - OR-to-memory writes accumulator OR memory word to memory and C.
// - XOR of accumulator and operand; masked operand ANDed with mask first.
// - Compare-equal skips one instruction on equality, else advances, no register change.
// - Unequal, greater, less compares skip on their own condition.
// - Masked word compare masks both memory word and accumulator.
// - Table scan compares accumulator with X successive words from operand address.
// - Scan match skips and loads X with match address; else X holds last address.
// - Scan variants match on unequal, greater or less.
// - Table compare pairs reference words from operand address with words from C.
// - Done: A holds reference word, C unknown address, X equals C low bits.
// - Table compare with X zero stops after 6 us, no-match results, A kept.
// - Unequal table compare matches where reference and unknown words differ.
// - Copy C to accumulator, masked by mask register when selected.
// - Copy index to accumulator low bits, clear upper, optional low mask.
// - Copy X to accumulator low bits; hold or clear upper bits.
// - Copy M or Q to accumulator, always ANDed with mask register.
`timescale 1ns/10ps
module lcu_core (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        start,
    input  wire lcu_pkg::lcu_op_e            opCode,
    input  wire logic                        masked,
    input  wire logic [lcu_pkg::WORD_W-1:0]  operand,
    input  wire logic [lcu_pkg::IDX_W-1:0]   operandAddr,
    input  wire logic [lcu_pkg::IDX_W-1:0]   currentAddr,
    input  wire lcu_pkg::lcu_regs_s          regsIn,
    output lcu_pkg::lcu_regs_s               regsOut,
    output logic [lcu_pkg::IDX_W-1:0]        nextAddr,
    output logic                             busy,
    output logic                             done,
    output lcu_pkg::lcu_mem_req_s            memReq,
    input  wire lcu_pkg::lcu_mem_rsp_s       memRsp
);
    localparam logic [lcu_pkg::IDX_W-1:0] LOW_ONES = '1;
    localparam logic [lcu_pkg::WORD_W-1:0] WORD_ONES = '1;

    lcu_pkg::lcu_state_s st;
    lcu_pkg::lcu_state_s next_st;

    logic [lcu_pkg::WORD_W-1:0] cmpLeft;
    logic [lcu_pkg::WORD_W-1:0] cmpRight;
    logic [lcu_pkg::WORD_W-1:0] cmpMask;
    logic                       cmpMasked;
    lcu_pkg::lcu_cmp_e          cmpKind;
    lcu_pkg::lcu_op_e           curOp;
    logic                       cmpHit;
    logic                       timerLoad;
    logic                       timerExpired;
    logic                       take;
    logic [lcu_pkg::WORD_W-1:0] opMasked;
    logic [lcu_pkg::WORD_W-1:0] wordMask;
    logic [lcu_pkg::IDX_W-1:0]  lowMask;

    assign take     = start && (st.phase == lcu_pkg::PH_IDLE);
    assign curOp    = take ? opCode : st.op;
    assign wordMask = masked ? regsIn.b : WORD_ONES;
    assign lowMask  = masked ? regsIn.b[lcu_pkg::IDX_W-1:0] : LOW_ONES;
    assign opMasked = operand & wordMask;

    // Comparator sources follow the phase: word compare, scan, or table pair
    always_comb begin
        cmpLeft   = regsIn.a;
        cmpRight  = operand;
        cmpMask   = regsIn.b;
        cmpMasked = masked;
        case (st.phase)
            lcu_pkg::PH_SCAN: begin
                cmpLeft   = st.regs.a;
                cmpRight  = memRsp.rdata;
                cmpMask   = st.regs.b;
                cmpMasked = st.masked;
            end
            lcu_pkg::PH_TUNK: begin
                cmpLeft   = st.refWord;
                cmpRight  = memRsp.rdata;
                cmpMask   = st.regs.b;
                cmpMasked = st.masked;
            end
            default: begin
            end
        endcase
        case (curOp)
            lcu_pkg::OP_CMP_NE, lcu_pkg::OP_SCAN_NE, lcu_pkg::OP_TCMP_NE: cmpKind = lcu_pkg::CMP_NE;
            lcu_pkg::OP_CMP_GR, lcu_pkg::OP_SCAN_GR:                      cmpKind = lcu_pkg::CMP_GR;
            lcu_pkg::OP_CMP_LS, lcu_pkg::OP_SCAN_LS:                      cmpKind = lcu_pkg::CMP_LS;
            default:                                                      cmpKind = lcu_pkg::CMP_EQ;
        endcase
    end

    lcu_compare #(.WIDTH(lcu_pkg::WORD_W)) u_compare (
        .left   (cmpLeft),
        .right  (cmpRight),
        .mask   (cmpMask),
        .masked (cmpMasked),
        .kind   (cmpKind),
        .hit    (cmpHit)
    );

    lcu_timer #(.CYCLES(lcu_pkg::ZERO_STOP_CYC)) u_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (timerLoad),
        .expired (timerExpired)
    );

    always_comb begin
        next_st   = st;
        next_st.done = 1'b0;
        timerLoad = 1'b0;
        case (st.phase)
            lcu_pkg::PH_IDLE: begin
                if (start) begin
                    next_st.regs   = regsIn;
                    next_st.op     = opCode;
                    next_st.masked = masked;
                    next_st.current_instruction_address    = currentAddr;
                    next_st.next_instruction_address    = currentAddr + lcu_pkg::STEP_ONE;
                    next_st.ptr    = operandAddr;
                    next_st.remain = regsIn.x;
                    next_st.done   = 1'b1;
                    case (opCode)
                        lcu_pkg::OP_IDX_DEC2: next_st.regs.i2 = regsIn.i2 - opMasked[lcu_pkg::IDX_W-1:0];
                        lcu_pkg::OP_IDX_DEC3: next_st.regs.i3 = regsIn.i3 - opMasked[lcu_pkg::IDX_W-1:0];
                        lcu_pkg::OP_AND:      next_st.regs.a  = regsIn.a & operand & wordMask;
                        lcu_pkg::OP_OR:       next_st.regs.a  = (regsIn.a | operand) & wordMask;
                        lcu_pkg::OP_XOR:      next_st.regs.a  = regsIn.a ^ opMasked;
                        lcu_pkg::OP_AND_MEM, lcu_pkg::OP_OR_MEM: begin
                            next_st.regs.c = (opCode == lcu_pkg::OP_AND_MEM) ? (regsIn.a & operand)
                                                                             : (regsIn.a | operand);
                            next_st.mem.req   = 1'b1;
                            next_st.mem.we    = 1'b1;
                            next_st.mem.addr  = operandAddr;
                            next_st.mem.wdata = next_st.regs.c;
                            next_st.done      = 1'b0;
                            next_st.phase     = lcu_pkg::PH_WRITE;
                        end
                        lcu_pkg::OP_CMP_EQ, lcu_pkg::OP_CMP_NE, lcu_pkg::OP_CMP_GR, lcu_pkg::OP_CMP_LS: begin
                            if (cmpHit) begin
                                next_st.next_instruction_address = currentAddr + lcu_pkg::STEP_SKIP;
                            end
                        end
                        lcu_pkg::OP_SCAN_EQ, lcu_pkg::OP_SCAN_NE, lcu_pkg::OP_SCAN_GR, lcu_pkg::OP_SCAN_LS,
                        lcu_pkg::OP_TCMP_EQ, lcu_pkg::OP_TCMP_NE: begin
                            next_st.done = 1'b0;
                            if (regsIn.x == lcu_pkg::IDX_RST) begin
                                timerLoad     = 1'b1;
                                next_st.phase = lcu_pkg::PH_ZERO;
                                next_st.regs.x = (opCode == lcu_pkg::OP_TCMP_EQ || opCode == lcu_pkg::OP_TCMP_NE)
                                               ? regsIn.c[lcu_pkg::IDX_W-1:0] : operandAddr;
                            end else begin
                                next_st.mem.req  = 1'b1;
                                next_st.mem.we   = 1'b0;
                                next_st.mem.addr = operandAddr;
                                next_st.phase    = (opCode == lcu_pkg::OP_TCMP_EQ || opCode == lcu_pkg::OP_TCMP_NE)
                                                 ? lcu_pkg::PH_TREF : lcu_pkg::PH_SCAN;
                            end
                        end
                        lcu_pkg::OP_COPY_C:  next_st.regs.a = regsIn.c & wordMask;
                        lcu_pkg::OP_COPY_I1: next_st.regs.a = {14'h0000, regsIn.i1 & lowMask};
                        lcu_pkg::OP_COPY_I2: next_st.regs.a = {14'h0000, regsIn.i2 & lowMask};
                        lcu_pkg::OP_COPY_I3: next_st.regs.a = {14'h0000, regsIn.i3 & lowMask};
                        lcu_pkg::OP_COPY_XH: next_st.regs.a = {regsIn.a[lcu_pkg::WORD_W-1:lcu_pkg::IDX_W],
                                                               regsIn.x & lowMask};
                        lcu_pkg::OP_COPY_XC: next_st.regs.a = {14'h0000, regsIn.x & lowMask};
                        lcu_pkg::OP_COPY_M:  next_st.regs.a = regsIn.m & regsIn.b;
                        lcu_pkg::OP_COPY_Q:  next_st.regs.a = regsIn.q & regsIn.b;
                        default: begin
                        end
                    endcase
                end
            end
            lcu_pkg::PH_WRITE: begin
                if (memRsp.valid) begin
                    next_st.mem.req = 1'b0;
                    next_st.done    = 1'b1;
                    next_st.phase   = lcu_pkg::PH_IDLE;
                end
            end
            lcu_pkg::PH_ZERO: begin
                if (timerExpired) begin
                    next_st.done  = 1'b1;
                    next_st.phase = lcu_pkg::PH_IDLE;
                end
            end
            lcu_pkg::PH_SCAN: begin
                if (memRsp.valid) begin
                    if (cmpHit || st.remain == lcu_pkg::STEP_ONE) begin
                        next_st.regs.x  = st.ptr;
                        next_st.next_instruction_address     = st.current_instruction_address + (cmpHit ? lcu_pkg::STEP_SKIP : lcu_pkg::STEP_ONE);
                        next_st.mem.req = 1'b0;
                        next_st.done    = 1'b1;
                        next_st.phase   = lcu_pkg::PH_IDLE;
                    end else begin
                        next_st.ptr      = st.ptr + lcu_pkg::STEP_ONE;
                        next_st.remain   = st.remain - lcu_pkg::STEP_ONE;
                        next_st.mem.addr = st.ptr + lcu_pkg::STEP_ONE;
                    end
                end
            end
            lcu_pkg::PH_TREF: begin
                if (memRsp.valid) begin
                    next_st.refWord  = memRsp.rdata;
                    next_st.mem.addr = st.regs.c[lcu_pkg::IDX_W-1:0];
                    next_st.phase    = lcu_pkg::PH_TUNK;
                end
            end
            lcu_pkg::PH_TUNK: begin
                if (memRsp.valid) begin
                    next_st.regs.a = st.refWord;
                    if (cmpHit || st.remain == lcu_pkg::STEP_ONE) begin
                        next_st.regs.x  = st.regs.c[lcu_pkg::IDX_W-1:0];
                        next_st.next_instruction_address     = st.current_instruction_address + (cmpHit ? lcu_pkg::STEP_SKIP : lcu_pkg::STEP_ONE);
                        next_st.mem.req = 1'b0;
                        next_st.done    = 1'b1;
                        next_st.phase   = lcu_pkg::PH_IDLE;
                    end else begin
                        next_st.ptr      = st.ptr + lcu_pkg::STEP_ONE;
                        next_st.regs.c   = st.regs.c + lcu_pkg::C_STEP;
                        next_st.remain   = st.remain - lcu_pkg::STEP_ONE;
                        next_st.mem.addr = st.ptr + lcu_pkg::STEP_ONE;
                        next_st.phase    = lcu_pkg::PH_TREF;
                    end
                end
            end
            default: next_st.phase = lcu_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign regsOut  = st.regs;
    assign nextAddr = st.next_instruction_address;
    assign done     = st.done;
    assign memReq   = st.mem;
    assign busy     = (st.phase != lcu_pkg::PH_IDLE);

    // Checks
    logic [lcu_pkg::IDX_W-1:0] opLow;
    logic                      isSearch;
    assign opLow    = operand[lcu_pkg::IDX_W-1:0];
    assign isSearch = (opCode >= lcu_pkg::OP_SCAN_EQ) && (opCode <= lcu_pkg::OP_TCMP_NE);

    localparam logic [15:0] ZERO_CNT_END = 16'(lcu_pkg::ZERO_STOP_CYC + 1);

    // Cycles since a zero-count search was taken; zero from the cycle after its done pulse until the next one is taken
    logic [15:0] zeroCnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            zeroCnt <= 16'h0000;
        end else if (take && isSearch && (regsIn.x == lcu_pkg::IDX_RST)) begin
            zeroCnt <= 16'h0001;
        end else if (st.phase == lcu_pkg::PH_ZERO) begin
            zeroCnt <= zeroCnt + 16'h0001;
        end else begin
            zeroCnt <= 16'h0000;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence zeroStart;
        take && isSearch && (regsIn.x == lcu_pkg::IDX_RST);
    endsequence

    idx_dec_a: assert property (take && opCode == lcu_pkg::OP_IDX_DEC2 && !masked
        |=> done && regsOut.i2 == $past(regsIn.i2) - $past(opLow)) else $error("index decrement wrong");
    idx_mask_a: assert property (take && opCode == lcu_pkg::OP_IDX_DEC3 && masked
        |=> regsOut.i3 == $past(regsIn.i3) - ($past(opLow) & $past(regsIn.b[13:0]))) else $error("masked decrement wrong");
    and_op_a: assert property (take && opCode == lcu_pkg::OP_AND
        |=> regsOut.a == ($past(regsIn.a) & $past(operand) & $past(wordMask))) else $error("and result wrong");
    or_op_a: assert property (take && opCode == lcu_pkg::OP_OR
        |=> regsOut.a == (($past(regsIn.a) | $past(operand)) & $past(wordMask))) else $error("or result wrong");
    xor_op_a: assert property (take && opCode == lcu_pkg::OP_XOR
        |=> regsOut.a == ($past(regsIn.a) ^ $past(opMasked))) else $error("xor result wrong");
    mem_write_a: assert property (st.phase == lcu_pkg::PH_WRITE
        |-> memReq.req && memReq.we && memReq.wdata == regsOut.c) else $error("memory write data differs from C");
    cmp_skip_a: assert property (take && opCode >= lcu_pkg::OP_CMP_EQ && opCode <= lcu_pkg::OP_CMP_LS
        |=> done && nextAddr == $past(currentAddr) + ($past(cmpHit) ? 14'h0002 : 14'h0001)
            && regsOut == $past(regsIn)) else $error("word compare skip wrong");
    zero_enter_a: assert property (zeroStart |=> st.phase == lcu_pkg::PH_ZERO && !done)
        else $error("zero count wait not entered");
    zero_stop_a: assert property ((zeroCnt != 16'h0000) |-> (done == (zeroCnt == ZERO_CNT_END)))
        else $error("zero count stop time wrong");
    copy_idx_a: assert property (take && opCode == lcu_pkg::OP_COPY_I2
        |=> regsOut.a[27:14] == 14'h0000 && regsOut.i2 == $past(regsIn.i2)) else $error("index copy wrong");
    tcmp_x_a: assert property (done && (st.op == lcu_pkg::OP_TCMP_EQ || st.op == lcu_pkg::OP_TCMP_NE)
        |-> regsOut.x == regsOut.c[13:0]) else $error("X differs from C low bits");
    copy_x_a: assert property (take && opCode == lcu_pkg::OP_COPY_XH
        |=> regsOut.a[27:14] == $past(regsIn.a[27:14]) && regsOut.x == $past(regsIn.x)) else $error("hold copy wrong");
    copy_mq_a: assert property (take && opCode == lcu_pkg::OP_COPY_M
        |=> regsOut.a == ($past(regsIn.m) & $past(regsIn.b))) else $error("M copy wrong");
endmodule

//--- sim/lcu_mem_model.sv
// Core memory model answering each held request after a chosen latency.
// Assumes the core holds every request until it sees valid.
`timescale 1ns/10ps
module lcu_mem_model (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [3:0]            lat,
    input  wire lcu_pkg::lcu_mem_req_s memReq,
    output lcu_pkg::lcu_mem_rsp_s      memRsp
);
    logic [lcu_pkg::WORD_W-1:0] word [0:255];
    logic [3:0]                 cnt;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memRsp <= '0;
            cnt    <= 4'h0;
        end else begin
            // Read data toggles whenever no answer is given
            memRsp.valid <= 1'b0;
            memRsp.rdata <= ~memRsp.rdata;
            if (memReq.req && !memRsp.valid) begin
                cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
                if (cnt == lat) begin
                    memRsp.valid <= 1'b1;
                    memRsp.rdata <= memReq.we ? memReq.wdata : word[memReq.addr[7:0]];
                    if (memReq.we) word[memReq.addr[7:0]] <= memReq.wdata;
                end
            end
        end
    end
endmodule

//--- sim/tb_lcu_core.sv
// Self-checking bench for the logic, compare and transfer datapath.
// Assumes the memory model beside it; inputs change 1 ns after each rising edge.
`timescale 1ns/10ps
module tb_lcu_core;
    localparam lcu_pkg::lcu_regs_s R0 = '{a: 28'h5a5a5a5, b: 28'h0ff00ff, c: 28'h0000030, x: 14'h0003,
        i1: 14'h1234, i2: 14'h0003, i3: 14'h0010, m: 28'h7654321, q: 28'h0abcdef};
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  start = 1'b0;
    lcu_pkg::lcu_op_e      opCode = lcu_pkg::OP_AND;
    logic                  masked = 1'b0;
    logic [27:0]           operand = 28'h0;
    logic [13:0]           operandAddr = 14'h0;
    lcu_pkg::lcu_regs_s    regsIn = R0;
    lcu_pkg::lcu_regs_s    regsOut;
    logic [13:0]           nextAddr;
    logic                  busy;
    logic                  done;
    lcu_pkg::lcu_mem_req_s memReq;
    lcu_pkg::lcu_mem_rsp_s memRsp;
    logic [3:0]            lat = 4'h0;
    int                    n_fail = 0;
    int                    checks_done = 0;
    int                    waited;
    always #5 clk = ~clk;
    lcu_core dut (.clk(clk), .rst_b(rst_b), .start(start), .opCode(opCode), .masked(masked), .operand(operand),
        .operandAddr(operandAddr), .currentAddr(14'h0100), .regsIn(regsIn), .regsOut(regsOut),
        .nextAddr(nextAddr), .busy(busy), .done(done), .memReq(memReq), .memRsp(memRsp));
    lcu_mem_model memory (.clk(clk), .rst_b(rst_b), .lat(lat), .memReq(memReq), .memRsp(memRsp));
    task give_verdict;
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [27:0] got, input logic [27:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Issue one operation and wait for its done pulse; leaves time 1 ns after that edge
    task op(input lcu_pkg::lcu_op_e o, input logic m, input logic [27:0] v, input logic [13:0] ea,
            input logic [1:0] step);
        @(posedge clk);
        #1;
        opCode = o;
        masked = m;
        operand = v;
        operandAddr = ea;
        start = 1'b1;
        waited = 0;
        do begin
            @(posedge clk);
            #1 start = 1'b0;
            waited++;
        end while (done !== 1'b1 && waited < 2000);
        chk({27'h0, done}, 28'h1);
        chk({27'h0, busy}, 28'h0);
        chk({14'h0, nextAddr}, {14'h0, 14'h0100 + {12'h0, step}});
    endtask
    task scan(input lcu_pkg::lcu_op_e o, input logic [27:0] a, input logic [13:0] ex, input logic [1:0] sk);
        regsIn.a = a;
        op(o, 1'b0, 28'h0, 14'h0010, sk);
        chk({14'h0, regsOut.x}, {14'h0, ex});
    endtask
    task tcmp(input lcu_pkg::lcu_op_e o, input logic [27:0] ea, input logic [13:0] ec, input logic [1:0] sk);
        op(o, 1'b0, 28'h0, 14'h0020, sk);
        chk(regsOut.a, ea);
        chk(regsOut.c, {14'h0, ec});
        chk({14'h0, regsOut.x}, {14'h0, ec});
        chk(regsOut.b, R0.b);
    endtask
    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 3; i++) begin
            memory.word[16 + i] = 28'(3 + 3 * i - (i == 1 ? 2 : 0) + (i == 1 ? 1 : 0));
            memory.word[32 + i] = 28'(i + 1);
        end
        memory.word[17] = 28'h7;
        memory.word[48] = 28'h1; memory.word[49] = 28'h5; memory.word[50] = 28'h3;
        memory.word[64] = 28'h3c3c3c3;
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        op(lcu_pkg::OP_IDX_DEC2, 1'b0, 28'h0000005, 14'h0, 2'd1); chk({14'h0, regsOut.i2}, 28'h3ffe);
        op(lcu_pkg::OP_IDX_DEC3, 1'b1, 28'h0001f11, 14'h0, 2'd1); chk({14'h0, regsOut.i3}, 28'h3fff);
        op(lcu_pkg::OP_AND, 1'b0, 28'h0f0f0f0, 14'h0, 2'd1); chk(regsOut.a, R0.a & 28'h0f0f0f0);
        op(lcu_pkg::OP_AND, 1'b1, 28'h0f0f0f0, 14'h0, 2'd1); chk(regsOut.a, R0.a & 28'h0f0f0f0 & R0.b);
        op(lcu_pkg::OP_OR, 1'b1, 28'h0f0f0f0, 14'h0, 2'd1); chk(regsOut.a, (R0.a | 28'h0f0f0f0) & R0.b);
        op(lcu_pkg::OP_XOR, 1'b1, 28'h0f0f0f0, 14'h0, 2'd1); chk(regsOut.a, R0.a ^ (28'h0f0f0f0 & R0.b));
        lat = 4'h2;
        op(lcu_pkg::OP_AND_MEM, 1'b0, 28'h3c3c3c3, 14'h0040, 2'd1); chk(regsOut.c, R0.a & 28'h3c3c3c3);
        chk(memory.word[64], R0.a & 28'h3c3c3c3);
        op(lcu_pkg::OP_OR_MEM, 1'b0, 28'h0000ff0, 14'h0041, 2'd1); chk(regsOut.c, R0.a | 28'h0000ff0);
        chk(memory.word[65], R0.a | 28'h0000ff0);
        regsIn.a = 28'h8000000;
        op(lcu_pkg::OP_CMP_EQ, 1'b0, 28'h1, 14'h0, 2'd1); chk(regsOut.a, 28'h8000000);
        op(lcu_pkg::OP_CMP_NE, 1'b0, 28'h1, 14'h0, 2'd2);
        op(lcu_pkg::OP_CMP_GR, 1'b0, 28'h1, 14'h0, 2'd1);
        op(lcu_pkg::OP_CMP_LS, 1'b0, 28'h1, 14'h0, 2'd2);
        regsIn.a = R0.a;
        op(lcu_pkg::OP_CMP_EQ, 1'b1, R0.a ^ 28'hf00ff00, 14'h0, 2'd2);
        op(lcu_pkg::OP_CMP_EQ, 1'b0, R0.a, 14'h0, 2'd2); chk(regsOut.c, R0.c);
        scan(lcu_pkg::OP_SCAN_EQ, 28'h7, 14'h0011, 2'd2);
        scan(lcu_pkg::OP_SCAN_NE, 28'h3, 14'h0011, 2'd2);
        scan(lcu_pkg::OP_SCAN_GR, 28'h7, 14'h0010, 2'd2);
        scan(lcu_pkg::OP_SCAN_LS, 28'h7, 14'h0012, 2'd2);
        scan(lcu_pkg::OP_SCAN_EQ, 28'h5, 14'h0012, 2'd1);
        regsIn.x = 14'h0;
        scan(lcu_pkg::OP_SCAN_EQ, 28'h5, 14'h0010, 2'd1); chk(28'(waited), 28'(lcu_pkg::ZERO_STOP_CYC + 1));
        regsIn = R0;
        tcmp(lcu_pkg::OP_TCMP_EQ, 28'h1, 14'h0030, 2'd2);
        tcmp(lcu_pkg::OP_TCMP_NE, 28'h2, 14'h0031, 2'd2);
        memory.word[48] = 28'h4; memory.word[50] = 28'h6;
        tcmp(lcu_pkg::OP_TCMP_EQ, 28'h3, 14'h0032, 2'd1);
        regsIn.x = 14'h0;
        op(lcu_pkg::OP_TCMP_EQ, 1'b0, 28'h0, 14'h0020, 2'd1); chk(regsOut.a, R0.a);
        chk(28'(waited), 28'(lcu_pkg::ZERO_STOP_CYC + 1));
        chk({14'h0, regsOut.x}, {14'h0, R0.c[13:0]});
        chk(regsOut.c, R0.c);
        regsIn = R0;
        op(lcu_pkg::OP_COPY_C, 1'b1, 28'h0, 14'h0, 2'd1); chk(regsOut.a, R0.c & R0.b);
        op(lcu_pkg::OP_COPY_I1, 1'b1, 28'h0, 14'h0, 2'd1); chk(regsOut.a, {14'h0, R0.i1 & R0.b[13:0]});
        op(lcu_pkg::OP_COPY_I2, 1'b0, 28'h0, 14'h0, 2'd1); chk(regsOut.a, {14'h0, R0.i2});
        op(lcu_pkg::OP_COPY_I3, 1'b1, 28'h0, 14'h0, 2'd1); chk(regsOut.a, {14'h0, R0.i3 & R0.b[13:0]});
        op(lcu_pkg::OP_COPY_XH, 1'b0, 28'h0, 14'h0, 2'd1); chk(regsOut.a, {R0.a[27:14], R0.x});
        op(lcu_pkg::OP_COPY_XC, 1'b0, 28'h0, 14'h0, 2'd1); chk(regsOut.a, {14'h0, R0.x});
        op(lcu_pkg::OP_COPY_M, 1'b0, 28'h0, 14'h0, 2'd1); chk(regsOut.a, R0.m & R0.b);
        op(lcu_pkg::OP_COPY_Q, 1'b0, 28'h0, 14'h0, 2'd1); chk(regsOut.a, R0.q & R0.b);
        give_verdict();
    end
endmodule
